// File: dv/port_event_checker.sv
// concurrent checks on the ports of the event flag bank
`timescale 1ns/10ps
module port_event_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_detection_done,
  input wire logic i_classification_done,
  input wire logic i_load_removed_shutdown,
  input wire logic i_overcurrent_shutdown,
  input wire logic i_class_overcurrent_seen,
  input wire logic i_overcurrent_cut_threshold,
  input wire logic i_supply_lockout,
  input wire logic i_global_flag_wipe,
  input wire logic o_irq_n,
  input wire logic o_port_hold_off
);
  // ----------------------------------------------------------------
  // one clock domain, reset disables every check
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // a read at one address, outside lockout so the flags can survive
  sequence s_rd(logic [7:0] a);
    i_reg_rd && i_reg_addr == a && !i_supply_lockout;
  endsequence

  rst_quiet_a: assert property ($fell(i_sys_rst) |-> o_port_hold_off &&
    o_irq_n && o_reg_rdata == 8'h00 && !o_reg_rvalid)
    else $error("outputs not quiet in reset");
  lockout_hold_a: assert property (i_supply_lockout |=> o_port_hold_off)
    else $error("port not held off in lockout");
  rvalid_pulse_a: assert property (!i_supply_lockout |=>
    o_reg_rvalid == $past(i_reg_rd)) else $error("read valid misplaced");
  reserved_zero_a: assert property (i_reg_rd && i_reg_addr > 8'h0c |=>
    o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  detect_seen_a: assert property (i_detection_done && !i_supply_lockout
    ##1 s_rd(8'h04) |=> o_reg_rdata[0]) else $error("detection not seen");
  take_clear_a: assert property (s_rd(8'h05) ##0
    !(i_detection_done || i_classification_done) ##1 s_rd(8'h04)
    |=> o_reg_rdata == 8'h00) else $error("take did not clear");
  set_wins_a: assert property (s_rd(8'h07) ##0 i_load_removed_shutdown
    ##1 s_rd(8'h06) |=> o_reg_rdata[4]) else $error("event lost in take");
  cut_default_a: assert property (i_overcurrent_shutdown &&
    !i_overcurrent_cut_threshold && !i_supply_lockout ##1 s_rd(8'h08)
    |=> o_reg_rdata[4]) else $error("class flag missed at default cut");
  wipe_clear_a: assert property (i_global_flag_wipe &&
    !(i_load_removed_shutdown || i_overcurrent_shutdown ||
    i_class_overcurrent_seen) ##1 s_rd(8'h06) |=> o_reg_rdata == 8'h00)
    else $error("wipe left fault flags");
endmodule

bind port_event_flag_bank port_event_checker i_port_event_checker (
  .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
  .i_detection_done, .i_classification_done, .i_load_removed_shutdown,
  .i_overcurrent_shutdown, .i_class_overcurrent_seen,
  .i_overcurrent_cut_threshold, .i_supply_lockout, .i_global_flag_wipe,
  .o_irq_n, .o_port_hold_off);

// File: dv/reg_host.sv
// host side model: serial slave byte accesses to the bank
`timescale 1ns/10ps
module reg_host (
  input wire logic i_clk,
  output logic [7:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask

  // single read; data and valid sampled just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1 d = i_reg_rdata;
    v = i_reg_rvalid;
  endtask

  // two reads back to back, strobe held high across both
  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                     output logic [7:0] d1, output logic [7:0] d2);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_addr <= b;
    #1 d1 = i_reg_rdata;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~b;
    #1 d2 = i_reg_rdata;
  endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the event flag bank
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pg = 1'b0, pe = 1'b0, thr = 1'b0, lock = 1'b0, cut = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [2:0] det_res = 3'h0, cls_res = 3'h0;
  logic [7:0] addr, wdata, rdata;
  logic rd, wr, rvalid, irq_n, hold_off;
  int failures = 0, checked = 0, cycles = 0;

  port_event_flag_bank i_port_event_flag_bank (.i_clk(clk),
    .i_sys_rst(sys_rst), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_power_good_state(pg), .i_port_powered_state(pe),
    .i_detection_done(ev[0]), .i_classification_done(ev[1]),
    .i_detect_outcome(det_res), .i_class_result(cls_res),
    .i_load_removed_shutdown(ev[2]), .i_overcurrent_shutdown(ev[3]),
    .i_class_overcurrent_seen(ev[4]), .i_overcurrent_cut_threshold(cut),
    .i_supply_overvoltage(ev[5]), .i_supply_undervoltage(ev[6]),
    .i_thermal_trip_seen(thr), .i_supply_lockout(lock),
    .i_global_flag_wipe(ev[7]), .o_irq_n(irq_n),
    .o_port_hold_off(hold_off));
  reg_host i_reg_host (.i_clk(clk), .o_reg_addr(addr), .o_reg_rd(rd),
    .o_reg_wr(wr), .o_reg_wdata(wdata), .i_reg_rdata(rdata),
    .i_reg_rvalid(rvalid));

  // ----------------------------------------------------------------
  // clock, hang guard and shared helpers
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      $display("[ERR] %0t run timed out", $time);
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // strobe bits: det, cls, load, ocut, cls_oc, ov, uv, wipe
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask

  task automatic peek(input logic [7:0] a, exp, input string what);
    logic [7:0] d;
    logic v;
    i_reg_host.rd(a, d, v);
    chk({7'h00, v}, 8'h01, "read valid");
    chk(d, exp, what);
  endtask

  // pin is read by reference, after the edge's updates have settled
  task automatic pin(ref logic got, input logic exp, input string what);
    #1 chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    peek(8'h01, 8'ha4, "mask default");
    for (int a = 2; a <= 12; a++) peek(a[7:0], 8'h00, "cleared");
    peek(8'h0d, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  // both edges count, whatever level is reached
  task automatic t_power;
    @(posedge clk);
    pg <= 1'b1;
    pe <= 1'b1;
    repeat (4) @(posedge clk);
    peek(8'h02, 8'h11, "both toggles");
    peek(8'h02, 8'h11, "peek keeps");
    peek(8'h03, 8'h11, "take");
    peek(8'h02, 8'h00, "after take");
    @(posedge clk);
    pg <= 1'b0;
    repeat (4) @(posedge clk);
    peek(8'h03, 8'h10, "falling good");
    $display("test power done");
  endtask

  task automatic t_detect;
    logic [7:0] d1, d2;
    @(posedge clk);
    det_res <= 3'h4;
    cls_res <= 3'h5;
    fork
      pulse(8'h03);
      i_reg_host.rd2(8'h05, 8'h04, d1, d2);
    join
    chk(d2, 8'h11, "set beats take");
    i_reg_host.rd2(8'h05, 8'h04, d1, d2);
    chk(d1, 8'h11, "detect flags");
    chk(d2, 8'h00, "take cleared");
    peek(8'h0c, 8'h54, "port results");
    $display("test detect done");
  endtask

  task automatic t_fault;
    logic [7:0] d1, d2;
    @(posedge clk);
    cut <= 1'b1;
    pulse(8'h04);
    pulse(8'h08);
    peek(8'h06, 8'h11, "fault flags");
    peek(8'h08, 8'h00, "cut only");
    peek(8'h07, 8'h11, "fault take");
    pulse(8'h10);
    peek(8'h06, 8'h00, "class only");
    peek(8'h09, 8'h10, "class flag");
    @(posedge clk);
    cut <= 1'b0;
    fork
      pulse(8'h08);
      i_reg_host.rd2(8'h07, 8'h08, d1, d2);
    join
    chk(d2, 8'h10, "default sets class");
    peek(8'h07, 8'h01, "default sets fault");
    peek(8'h09, 8'h10, "class take");
    pulse(8'h10);
    peek(8'h06, 8'h01, "class sets fault");
    fork
      pulse(8'h04);
      i_reg_host.rd2(8'h07, 8'h06, d1, d2);
    join
    chk(d2, 8'h10, "load kept");
    fork
      pulse(8'h80);
      i_reg_host.rd2(8'h06, 8'h06, d1, d2);
    join
    chk(d2, 8'h00, "wipe fault");
    peek(8'h08, 8'h00, "wipe startup");
    $display("test fault done");
  endtask

  task automatic t_supply;
    pulse(8'h20);
    pulse(8'h40);
    peek(8'h0a, 8'h0c, "ov and uv");
    peek(8'h0b, 8'h0c, "supply take");
    peek(8'h0a, 8'h00, "supply clear");
    $display("test supply done");
  endtask

  task automatic t_irq;
    i_reg_host.wr(8'h01, 8'h08);
    peek(8'h01, 8'h08, "mask write");
    pulse(8'h01);
    repeat (2) @(posedge clk);
    pin(irq_n, 1'b0, "irq enabled");
    i_reg_host.wr(8'h01, 8'h80);
    repeat (2) @(posedge clk);
    pin(irq_n, 1'b1, "irq masked");
    peek(8'h00, 8'h08, "masked latch");
    pulse(8'h20);
    repeat (2) @(posedge clk);
    pin(irq_n, 1'b0, "supply irq");
    i_reg_host.wr(8'h02, 8'hff);
    peek(8'h02, 8'h00, "write ignored");
    $display("test irq done");
  endtask

  // lockout acts as a reset in mid-run
  task automatic t_lockout;
    @(posedge clk);
    lock <= 1'b1;
    thr <= 1'b1;
    repeat (3) @(posedge clk);
    pin(hold_off, 1'b1, "held off");
    pin(irq_n, 1'b1, "irq quiet");
    @(posedge clk);
    lock <= 1'b0;
    repeat (2) @(posedge clk);
    thr <= 1'b0;
    pin(hold_off, 1'b0, "released");
    peek(8'h0a, 8'h90, "thermal and exit");
    peek(8'h01, 8'ha4, "mask restored");
    peek(8'h04, 8'h00, "detect cleared");
    $display("test lockout done");
  endtask

  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_power;
    t_detect;
    t_fault;
    t_supply;
    t_irq;
    t_lockout;
    print_verdict;
  end
endmodule

// File: rtl/change_detect.sv
// per-bit transition detector for status levels
`timescale 1ns/10ps
module change_detect #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_toggled
);
  logic [WIDTH-1:0] last_level;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("change_detect needs at least one bit");
    end
  endgenerate

  // levels start low after reset, so a level already high counts once
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_level <= '0;
    end else begin
      last_level <= i_level;
    end
  end

  // rising and falling edges alike
  assign o_toggled = i_level ^ last_level;
endmodule

// File: rtl/event_flag_reg.sv
// one sticky event register with set-wins clear
`timescale 1ns/10ps
`include "port_event_map.svh"
module event_flag_reg #(
  parameter int WIDTH = 8,
  parameter logic [7:0] VALID = 8'hff
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_flags
);
  generate
    if (WIDTH != 8) begin : g_bad_width
      $error("event_flag_reg serves 8-bit registers only");
    end
  endgenerate

  // a set in the clearing cycle survives the clear; reserved bits stay 0
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flags <= `EVENT_RESET;
    end else if (i_clear) begin
      o_flags <= i_set & VALID;
    end else begin
      o_flags <= o_flags | (i_set & VALID);
    end
  end
endmodule

// File: rtl/port_event_flag_bank.sv
// event flag bank of a single-port power controller
`timescale 1ns/10ps
`include "port_event_map.svh"
module port_event_flag_bank
  import port_event_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_power_good_state,
  input wire logic i_port_powered_state,
  input wire logic i_detection_done,
  input wire logic i_classification_done,
  input wire logic [2:0] i_detect_outcome,
  input wire logic [2:0] i_class_result,
  input wire logic i_load_removed_shutdown,
  input wire logic i_overcurrent_shutdown,
  input wire logic i_class_overcurrent_seen,
  input wire logic i_overcurrent_cut_threshold,
  input wire logic i_supply_overvoltage,
  input wire logic i_supply_undervoltage,
  input wire logic i_thermal_trip_seen,
  input wire logic i_supply_lockout,
  input wire logic i_global_flag_wipe,
  output logic o_irq_n,
  output logic o_port_hold_off
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  generate
    if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_bus
      $error("register port is fixed at 8-bit address and data");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic core_rst;
  logic prev_core_rst;
  logic prev_lockout;
  logic leaving_reset;
  reg_sel_t sel;
  logic take_access;
  logic [1:0] level_now;
  logic [1:0] level_toggled;
  logic [7:0] interrupt_enable_mask;
  logic [7:0] port_result_status;
  logic [7:0] power_set;
  logic [7:0] detect_set;
  logic [7:0] fault_set;
  logic [7:0] startup_set;
  logic [7:0] supply_set;
  logic power_clear;
  logic detect_clear;
  logic fault_clear;
  logic startup_clear;
  logic supply_clear;
  logic [7:0] power_event;
  logic [7:0] detect_event;
  logic [7:0] fault_event;
  logic [7:0] startup_event;
  logic [7:0] supply_event;
  logic [7:0] summary;
  logic [7:0] next_rdata;
  logic class_ovc_flag;
  logic ovc_fault_flag;

  // ----------------------------------------------------------------
  // internal reset and supply lockout
  // ----------------------------------------------------------------
  // supply below lockout keeps the whole bank in reset
  assign core_rst = i_sys_rst | i_supply_lockout;

  // history of the reset cause; prev_core_rst loads 1 while in reset, so no own reset
  always_ff @(posedge i_clk) begin
    prev_core_rst <= core_rst;
    prev_lockout <= i_supply_lockout;
  end

  // first running cycle after any reset has released
  assign leaving_reset = prev_core_rst & ~core_rst;

  // port is held unpowered during reset and lockout
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      o_port_hold_off <= 1'b1;
    end else begin
      o_port_hold_off <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address decode for the serial slave's byte port
  // ----------------------------------------------------------------
  assign sel = decode_sel(i_reg_addr);
  // take addresses are the odd offsets of the event pairs
  assign take_access = i_reg_rd & i_reg_addr[0];

  // clear-on-read strobes, plus the global wipe
  assign power_clear = i_global_flag_wipe |
    (take_access & (sel == SEL_POWER));
  assign detect_clear = i_global_flag_wipe |
    (take_access & (sel == SEL_DETECT));
  assign fault_clear = i_global_flag_wipe |
    (take_access & (sel == SEL_FAULT));
  assign startup_clear = i_global_flag_wipe |
    (take_access & (sel == SEL_STARTUP));
  assign supply_clear = i_global_flag_wipe |
    (take_access & (sel == SEL_SUPPLY));

  // ----------------------------------------------------------------
  // power event sources
  // ----------------------------------------------------------------
  assign level_now = {i_power_good_state, i_port_powered_state};

  change_detect #(
    .WIDTH(2)
  ) u_power_edges (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_level(level_now),
    .o_toggled(level_toggled)
  );

  // either edge counts, whatever level is reached
  always_comb begin
    power_set = `EVENT_RESET;
    power_set[`BIT_POWER_GOOD_TOGGLED] = level_toggled[1];
    power_set[`BIT_PORT_POWER_TOGGLED] = level_toggled[0];
  end

  // ----------------------------------------------------------------
  // detection and classification sources
  // ----------------------------------------------------------------
  always_comb begin
    detect_set = `EVENT_RESET;
    detect_set[`BIT_DETECTION_DONE] = i_detection_done;
    detect_set[`BIT_CLASSIFICATION_DONE] = i_classification_done;
  end

  // ----------------------------------------------------------------
  // overcurrent flag steering
  // ----------------------------------------------------------------
  // with the cut threshold on its automatic default both comparators
  // share one threshold, so either event marks both flags; once it is
  // reprogrammed each flag follows only its own comparator
  always_comb begin
    if (!i_overcurrent_cut_threshold) begin
      class_ovc_flag = i_class_overcurrent_seen |
        i_overcurrent_shutdown;
      ovc_fault_flag = i_class_overcurrent_seen |
        i_overcurrent_shutdown;
    end else begin
      class_ovc_flag = i_class_overcurrent_seen;
      ovc_fault_flag = i_overcurrent_shutdown;
    end
  end

  // ----------------------------------------------------------------
  // fault and startup sources
  // ----------------------------------------------------------------
  always_comb begin
    fault_set = `EVENT_RESET;
    fault_set[`BIT_LOAD_REMOVED] = i_load_removed_shutdown;
    fault_set[`BIT_OVERCURRENT_SHUTDOWN] = ovc_fault_flag;
  end

  always_comb begin
    startup_set = `EVENT_RESET;
    startup_set[`BIT_CLASS_OVERCURRENT] = class_ovc_flag;
  end

  // ----------------------------------------------------------------
  // supply sources
  // ----------------------------------------------------------------
  // thermal and lockout causes are caught at reset release, since the
  // reset itself wipes every flag that could have recorded them
  always_comb begin
    supply_set = `EVENT_RESET;
    supply_set[`BIT_SUPPLY_OVERVOLTAGE] = i_supply_overvoltage;
    supply_set[`BIT_SUPPLY_UNDERVOLTAGE] = i_supply_undervoltage;
    supply_set[`BIT_THERMAL_TRIP] = leaving_reset &
      i_thermal_trip_seen;
    supply_set[`BIT_SUPPLY_LOCKOUT_EXIT] = leaving_reset &
      prev_lockout;
  end

  // ----------------------------------------------------------------
  // sticky event registers
  // ----------------------------------------------------------------
  // each clears to zero on reset and keeps a same-cycle set
  event_flag_reg #(
    .WIDTH(8),
    .VALID(`POWER_VALID)
  ) u_power_event (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_set(power_set),
    .i_clear(power_clear),
    .o_flags(power_event)
  );

  event_flag_reg #(
    .WIDTH(8),
    .VALID(`DETECT_VALID)
  ) u_detect_event (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_set(detect_set),
    .i_clear(detect_clear),
    .o_flags(detect_event)
  );

  event_flag_reg #(
    .WIDTH(8),
    .VALID(`FAULT_VALID)
  ) u_fault_event (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_set(fault_set),
    .i_clear(fault_clear),
    .o_flags(fault_event)
  );

  event_flag_reg #(
    .WIDTH(8),
    .VALID(`STARTUP_VALID)
  ) u_startup_event (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_set(startup_set),
    .i_clear(startup_clear),
    .o_flags(startup_event)
  );

  event_flag_reg #(
    .WIDTH(8),
    .VALID(`SUPPLY_VALID)
  ) u_supply_event (
    .i_clk(i_clk),
    .i_sys_rst(core_rst),
    .i_set(supply_set),
    .i_clear(supply_clear),
    .o_flags(supply_event)
  );

  // ----------------------------------------------------------------
  // interrupt enable mask
  // ----------------------------------------------------------------
  // all eight bits writable; other addresses ignore writes
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      interrupt_enable_mask <= `IRQ_MASK_RESET;
    end else if (i_reg_wr && sel == SEL_MASK) begin
      interrupt_enable_mask <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // port status: latched results of the last phases
  // ----------------------------------------------------------------
  // bits 7 and 3 are never loaded and so read zero
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      port_result_status <= `EVENT_RESET;
    end else begin
      if (i_detection_done) begin
        port_result_status[`PORT_DET_LSB +: 3] <= i_detect_outcome;
      end
      if (i_classification_done) begin
        port_result_status[`PORT_CLASS_LSB +: 3] <= i_class_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt summary and output
  // ----------------------------------------------------------------
  // summary mirrors the flags, masked or not, so a wipe of the flags
  // also wipes the summary
  always_comb begin
    summary = `EVENT_RESET;
    summary[7] = |supply_event;
    summary[6] = startup_event[`BIT_CLASS_OVERCURRENT];
    summary[5] = fault_event[`BIT_OVERCURRENT_SHUTDOWN];
    summary[4] = detect_event[`BIT_CLASSIFICATION_DONE];
    summary[3] = detect_event[`BIT_DETECTION_DONE];
    summary[2] = fault_event[`BIT_LOAD_REMOVED];
    summary[1] = power_event[`BIT_POWER_GOOD_TOGGLED];
    summary[0] = power_event[`BIT_PORT_POWER_TOGGLED];
  end

  // registered so the pin never glitches on a mask write
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= ~|(summary & interrupt_enable_mask);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped and reserved addresses answer zero
  always_comb begin
    case (sel)
      SEL_SUMMARY: next_rdata = summary;
      SEL_MASK: next_rdata = interrupt_enable_mask;
      SEL_POWER: next_rdata = power_event;
      SEL_DETECT: next_rdata = detect_event;
      SEL_FAULT: next_rdata = fault_event;
      SEL_STARTUP: next_rdata = startup_event;
      SEL_SUPPLY: next_rdata = supply_event;
      SEL_PORT: next_rdata = port_result_status;
      default: next_rdata = `EVENT_RESET;
    endcase
  end

  // data is sampled before the take clears, in the same edge
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      o_reg_rdata <= `EVENT_RESET;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// File: rtl/port_event_map.svh
// register offsets, field positions and reset values of the event bank
`ifndef PORT_EVENT_MAP_SVH
`define PORT_EVENT_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_SUMMARY 8'h00
`define ADDR_IRQ_MASK 8'h01
`define ADDR_POWER_PEEK 8'h02
`define ADDR_POWER_TAKE 8'h03
`define ADDR_DETECT_PEEK 8'h04
`define ADDR_DETECT_TAKE 8'h05
`define ADDR_FAULT_PEEK 8'h06
`define ADDR_FAULT_TAKE 8'h07
`define ADDR_STARTUP_PEEK 8'h08
`define ADDR_STARTUP_TAKE 8'h09
`define ADDR_SUPPLY_PEEK 8'h0a
`define ADDR_SUPPLY_TAKE 8'h0b
`define ADDR_PORT_STATUS 8'h0c

// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define IRQ_MASK_RESET 8'ha4
`define EVENT_RESET 8'h00
`define POWER_VALID 8'h11
`define DETECT_VALID 8'h11
`define FAULT_VALID 8'h11
`define STARTUP_VALID 8'h10
`define SUPPLY_VALID 8'h9c

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define BIT_PORT_POWER_TOGGLED 0
`define BIT_POWER_GOOD_TOGGLED 4
`define BIT_DETECTION_DONE 0
`define BIT_CLASSIFICATION_DONE 4
`define BIT_OVERCURRENT_SHUTDOWN 0
`define BIT_LOAD_REMOVED 4
`define BIT_CLASS_OVERCURRENT 4
`define BIT_SUPPLY_UNDERVOLTAGE 2
`define BIT_SUPPLY_OVERVOLTAGE 3
`define BIT_SUPPLY_LOCKOUT_EXIT 4
`define BIT_THERMAL_TRIP 7
`define PORT_DET_LSB 0
`define PORT_CLASS_LSB 4

`endif

// File: rtl/port_event_pkg.sv
// types and address decoding shared by the event bank files
package port_event_pkg;
  `include "port_event_map.svh"

  // which register an address selects
  typedef enum logic [3:0] {
    SEL_SUMMARY = 4'h0,
    SEL_MASK = 4'h1,
    SEL_POWER = 4'h2,
    SEL_DETECT = 4'h3,
    SEL_FAULT = 4'h4,
    SEL_STARTUP = 4'h5,
    SEL_SUPPLY = 4'h6,
    SEL_PORT = 4'h7,
    SEL_NONE = 4'h8
  } reg_sel_t;

  // address to register, peek and take alike
  function automatic reg_sel_t decode_sel(input logic [7:0] addr);
    case (addr)
      `ADDR_SUMMARY: decode_sel = SEL_SUMMARY;
      `ADDR_IRQ_MASK: decode_sel = SEL_MASK;
      `ADDR_POWER_PEEK, `ADDR_POWER_TAKE: decode_sel = SEL_POWER;
      `ADDR_DETECT_PEEK, `ADDR_DETECT_TAKE: decode_sel = SEL_DETECT;
      `ADDR_FAULT_PEEK, `ADDR_FAULT_TAKE: decode_sel = SEL_FAULT;
      `ADDR_STARTUP_PEEK, `ADDR_STARTUP_TAKE: decode_sel = SEL_STARTUP;
      `ADDR_SUPPLY_PEEK, `ADDR_SUPPLY_TAKE: decode_sel = SEL_SUPPLY;
      `ADDR_PORT_STATUS: decode_sel = SEL_PORT;
      default: decode_sel = SEL_NONE;
    endcase
  endfunction
endpackage
